/* verilog/iwc_defines.svh */
// Constants of the interrupt and wake-up control block.
`ifndef IWC_DEFINES_SVH
`define IWC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define IWC_OFS_FLAGS    12'h000
`define IWC_OFS_ENABLE   12'h004
`define IWC_OFS_EDGE     12'h008
`define IWC_OFS_STACK    12'h00C
`define IWC_OFS_WAKE     12'h010
`define IWC_OFS_DIE      12'h014
`define IWC_OFS_STATUS   12'h018

// ----------------------------------------------------------------------------
// Widths, reset values, fields and timing
// ----------------------------------------------------------------------------
`define IWC_NLINES       7
`define IWC_NPINS        8
`define IWC_EDGE_W       14
`define IWC_SP_RST       8'h00
`define IWC_EDGE_RST     14'h0000
`define IWC_WAKE_FAST_BIT 5
`define IWC_VECTOR       16'h0010
`define IWC_SP_STEP      8'h02
`define IWC_LIGHT_WAKE_MASK 7'h78
`define IWC_WAKE_FAST_LRO   12'h02D
`define IWC_WAKE_NORM_LRO   12'hBB8
`define IWC_EDGE_BOTH    2'h0
`define IWC_EDGE_RISE    2'h1
`define IWC_EDGE_FALL    2'h2

`endif

/* verilog/iwc_pkg.sv */
// Types shared by the interrupt and wake-up control block.
`default_nettype none
package iwc_pkg;

    // Sequencer states of the controller.
    typedef enum logic [2:0] {
        IWC_ST_RUN   = 3'b000,
        IWC_ST_POPA  = 3'b001,
        IWC_ST_POPB  = 3'b010,
        IWC_ST_SLEEP = 3'b011,
        IWC_ST_WAKE  = 3'b100
    } iwc_state_e;

    // Operating modes.
    typedef enum logic [1:0] {
        IWC_MODE_RUN   = 2'b00,
        IWC_MODE_LIGHT = 2'b01,
        IWC_MODE_DEEP  = 2'b10
    } iwc_mode_e;

    // Instruction strobes from the core, one cycle each.
    typedef struct packed {
        logic global_enable_instr;
        logic global_disable_instr;
        logic return_from_interrupt;
        logic push_acc_flags;
        logic pop_acc_flags;
        logic enter_light_sleep;
        logic enter_deep_sleep;
    } iwc_instr_s;

    // Stack memory port toward data memory.
    typedef struct packed {
        logic        we;
        logic        re;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } iwc_mem_s;

    // Program counter redirect toward the core.
    typedef struct packed {
        logic        load;
        logic [15:0] value;
    } iwc_pc_s;

    // Accumulator and flag restore toward the core.
    typedef struct packed {
        logic       load;
        logic [7:0] acc;
        logic [7:0] flags;
    } iwc_af_s;

    // Power controls.
    typedef struct packed {
        logic       sys_clk_off;
        logic       osc_stop_all;
        logic       prog_mem_off;
        logic       cpu_hold;
        logic [2:0] timer_run;
    } iwc_pwr_s;

endpackage
`default_nettype wire

/* verilog/iwc_edge.sv */
// Edge detector with rising, falling or both-edge selection.
`default_nettype none
`include "iwc_defines.svh"
module iwc_edge
    import iwc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Level in, selection and event out.
    input  wire logic       level,
    input  wire logic [1:0] sel,
    output logic            pulse
);
    typedef struct packed {
        logic prev;
    } iwc_edge_s;

    iwc_edge_s st;
    iwc_edge_s next_st;

    // Remember the previous level.
    always_comb begin
        next_st      = st;
        next_st.prev = level;
    end

    // Decode the selected edge against the previous level.
    always_comb begin
        case (sel)
            `IWC_EDGE_RISE: pulse = level & ~st.prev;
            `IWC_EDGE_FALL: pulse = ~level & st.prev;
            default:        pulse = level ^ st.prev;
        endcase
    end

    // Register the state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* verilog/iwc_wake_timer.sv */
// Wake-up delay counter timed in low-rate oscillator periods.
`default_nettype none
`include "iwc_defines.svh"
module iwc_wake_timer
    import iwc_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Control.
    input  wire logic start,
    input  wire logic fast,
    input  wire logic lro_tick,
    // Status.
    output logic      busy,
    output logic      done
);
    typedef struct packed {
        logic        busy;
        logic [11:0] cnt;
    } iwc_wt_s;

    iwc_wt_s st;
    iwc_wt_s next_st;

    // Load the selected delay, then count down one per oscillator period.
    always_comb begin
        next_st = st;
        done    = 1'b0;
        if (start) begin
            next_st.busy = 1'b1;
            next_st.cnt  = fast ? `IWC_WAKE_FAST_LRO : `IWC_WAKE_NORM_LRO;
        end else if (st.busy && lro_tick) begin
            if (st.cnt == 12'h001) begin
                next_st.busy = 1'b0;
                done         = 1'b1;
            end
            next_st.cnt = st.cnt - 12'h001;
        end
    end

    assign busy = st.busy;

    // Register the state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* verilog/iwc_ctrl.sv */
// Interrupt flags, vectored entry and return, and sleep/wake control.
`default_nettype none
`include "iwc_defines.svh"
module iwc_ctrl
    import iwc_pkg::*;
#(
    parameter bit FAST_BOOT = 1'b0
)(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Request sources.
    input  wire logic [1:0]  ext_pin,
    input  wire logic [4:0]  periph_req,
    input  wire logic [7:0]  wake_pin,
    input  wire logic        low_rate_osc,
    // Core interface.
    input  wire iwc_instr_s  instr,
    input  wire logic        irq_boundary,
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0]  acc_in,
    input  wire logic [7:0]  flags_in,
    output iwc_pc_s          pc_out,
    output iwc_af_s          af_out,
    output logic             irq_taken,
    // Stack memory.
    output iwc_mem_s         mem,
    input  wire logic [15:0] mem_rdata,
    // Timer clock sources and power controls.
    input  wire logic [2:0]  timer_clk_is_sys,
    input  wire logic [2:0]  timer_osc_en,
    output iwc_pwr_s         pwr
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        iwc_state_e  state;
        iwc_mode_e   mode;
        logic        pop_af;
        logic        gie;
        logic [6:0]  flags;
        logic [6:0]  enable;
        logic [13:0] edge_sel;
        logic [7:0]  stack_pointer;
        logic [7:0]  wake_ctrl;
        logic [7:0]  die;
        logic [1:0]  ext_s1;
        logic [1:0]  ext_s2;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic [7:0]  pin_prev;
        logic        lro_s1;
        logic        lro_s2;
        logic        lro_prev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        iwc_pc_s     pc;
        iwc_af_s     af;
        logic        irq_taken;
        iwc_mem_s    mem;
        iwc_pwr_s    pwr;
    } iwc_ctrl_s;

    iwc_ctrl_s  st;
    iwc_ctrl_s  next_st;
    logic [6:0] line_level;
    logic [6:0] line_event;
    logic [7:0] pin_toggle;
    logic       lro_tick;
    logic       fast_sel;
    logic       wake_start;
    logic       wake_busy;
    logic       wake_done;
    logic       take_irq;
    logic       apb_wr;

    // Register read decode, used for read data and for the error answer.
    function automatic logic [32:0] rd_decode(input logic [11:0] a, input iwc_ctrl_s s);
        case (a)
            `IWC_OFS_FLAGS:  rd_decode = {1'b1, 25'h000_0000, s.flags};
            `IWC_OFS_ENABLE: rd_decode = {1'b1, 25'h000_0000, s.enable};
            `IWC_OFS_EDGE:   rd_decode = {1'b1, 18'h0_0000, s.edge_sel};
            `IWC_OFS_STACK:  rd_decode = {1'b1, 24'h00_0000, s.stack_pointer};
            `IWC_OFS_WAKE:   rd_decode = {1'b1, 24'h00_0000, s.wake_ctrl};
            `IWC_OFS_DIE:    rd_decode = {1'b1, 24'h00_0000, s.die};
            `IWC_OFS_STATUS: rd_decode = {1'b1, 26'h000_0000, s.state, s.mode, s.gie};
            default:         rd_decode = {1'b0, 32'h0000_0000};
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Request edge detection
    // ------------------------------------------------------------------------
    // Pins pass the synchroniser; on-chip requests are already on this clock.
    assign line_level = {periph_req, st.ext_s2};

    generate
        for (genvar i = 0; i < `IWC_NLINES; i++) begin : g_line
            iwc_edge u_edge (
                .clk   (clk),
                .rst   (rst),
                .level (line_level[i]),
                .sel   (st.edge_sel[2*i +: 2]),
                .pulse (line_event[i])
            );
        end
    endgenerate

    // Pin wake sources and oscillator tick, all from second synchroniser stages.
    assign pin_toggle = (st.pin_s2 ^ st.pin_prev) & st.die;
    assign lro_tick   = st.lro_s2 & ~st.lro_prev;
    assign fast_sel   = FAST_BOOT | st.wake_ctrl[`IWC_WAKE_FAST_BIT];
    assign take_irq   = (st.state == IWC_ST_RUN) && irq_boundary && st.gie
                        && |(st.flags & st.enable);
    assign apb_wr     = psel & penable & pwrite & st.pready;
    assign wake_start = (st.state == IWC_ST_SLEEP) &&
                        ((|pin_toggle) ||
                         (st.mode == IWC_MODE_LIGHT &&
                          |(line_event & `IWC_LIGHT_WAKE_MASK)));

    iwc_wake_timer u_wake (
        .clk      (clk),
        .rst      (rst),
        .start    (wake_start),
        .fast     (fast_sel),
        .lro_tick (lro_tick),
        .busy     (wake_busy),
        .done     (wake_done)
    );

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    // Pulses default low each cycle; the sequencer raises them for one cycle.
    always_comb begin
        logic [32:0] rd;
        rd               = rd_decode(paddr, st);
        next_st          = st;
        next_st.ext_s1   = ext_pin;
        next_st.ext_s2   = st.ext_s1;
        next_st.pin_s1   = wake_pin;
        next_st.pin_s2   = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        next_st.lro_s1   = low_rate_osc;
        next_st.lro_s2   = st.lro_s1;
        next_st.lro_prev = st.lro_s2;
        next_st.mem      = '0;
        next_st.mem.addr = st.mem.addr;
        next_st.pc.load  = 1'b0;
        next_st.af.load  = 1'b0;
        next_st.irq_taken = 1'b0;

        // Register bus: data captured in setup, answered in the access phase.
        next_st.pready  = psel & ~penable;
        next_st.pslverr = psel & ~penable & ~rd[32];
        next_st.prdata  = (psel & ~penable & ~pwrite) ? rd[31:0] : 32'h0000_0000;
        if (apb_wr && !st.pslverr) begin
            case (paddr)
                `IWC_OFS_FLAGS:  next_st.flags = st.flags & pwdata[6:0];
                `IWC_OFS_ENABLE: next_st.enable = pwdata[6:0];
                `IWC_OFS_EDGE:   next_st.edge_sel = pwdata[13:0];
                `IWC_OFS_STACK:  next_st.stack_pointer = pwdata[7:0];
                `IWC_OFS_WAKE:   next_st.wake_ctrl = pwdata[7:0];
                `IWC_OFS_DIE:    next_st.die = pwdata[7:0];
                default:         next_st.flags = next_st.flags;
            endcase
        end
        // Hardware set wins over a clearing write, regardless of enables.
        next_st.flags = next_st.flags | line_event;

        // Sequencer.
        case (st.state)
            IWC_ST_RUN: begin
                if (take_irq) begin
                    next_st.mem.we        = 1'b1;
                    next_st.mem.addr      = st.stack_pointer;
                    next_st.mem.wdata     = pc_in;
                    next_st.stack_pointer = st.stack_pointer + `IWC_SP_STEP;
                    next_st.gie           = 1'b0;
                    next_st.pc.load       = 1'b1;
                    next_st.pc.value      = `IWC_VECTOR;
                    next_st.irq_taken     = 1'b1;
                end else if (instr.return_from_interrupt || instr.pop_acc_flags) begin
                    next_st.mem.re        = 1'b1;
                    next_st.mem.addr      = st.stack_pointer - `IWC_SP_STEP;
                    next_st.stack_pointer = st.stack_pointer - `IWC_SP_STEP;
                    next_st.pop_af        = instr.pop_acc_flags;
                    next_st.state         = IWC_ST_POPA;
                end else if (instr.push_acc_flags) begin
                    next_st.mem.we        = 1'b1;
                    next_st.mem.addr      = st.stack_pointer;
                    next_st.mem.wdata     = {acc_in, flags_in};
                    next_st.stack_pointer = st.stack_pointer + `IWC_SP_STEP;
                end else if (instr.enter_light_sleep || instr.enter_deep_sleep) begin
                    next_st.mode  = instr.enter_deep_sleep ? IWC_MODE_DEEP
                                                           : IWC_MODE_LIGHT;
                    next_st.state = IWC_ST_SLEEP;
                end else if (instr.global_enable_instr) begin
                    next_st.gie = 1'b1;
                end else if (instr.global_disable_instr) begin
                    next_st.gie = 1'b0;
                end
            end
            IWC_ST_POPA: begin
                next_st.state = IWC_ST_POPB;
            end
            IWC_ST_POPB: begin
                if (st.pop_af) begin
                    next_st.af.load  = 1'b1;
                    next_st.af.acc   = mem_rdata[15:8];
                    next_st.af.flags = mem_rdata[7:0];
                end else begin
                    next_st.pc.load  = 1'b1;
                    next_st.pc.value = mem_rdata;
                    next_st.gie      = 1'b1;
                end
                next_st.state = IWC_ST_RUN;
            end
            IWC_ST_SLEEP: begin
                if (wake_start) begin
                    next_st.state = IWC_ST_WAKE;
                end
            end
            IWC_ST_WAKE: begin
                if (wake_done) begin
                    next_st.state = IWC_ST_RUN;
                    next_st.mode  = IWC_MODE_RUN;
                end
            end
            default: begin
                next_st.state = IWC_ST_RUN;
            end
        endcase

        // Power controls follow the next state so they line up with it.
        next_st.pwr.cpu_hold     = next_st.state != IWC_ST_RUN;
        next_st.pwr.sys_clk_off  = next_st.state == IWC_ST_SLEEP ||
                                   next_st.state == IWC_ST_WAKE;
        next_st.pwr.osc_stop_all = next_st.state == IWC_ST_SLEEP &&
                                   next_st.mode == IWC_MODE_DEEP;
        next_st.pwr.prog_mem_off = next_st.state == IWC_ST_SLEEP;
        // Timers with their oscillator off halt; while the system clock is off, timers on it halt too; deep sleep halts all.
        if (next_st.state == IWC_ST_SLEEP && next_st.mode == IWC_MODE_DEEP) begin
            next_st.pwr.timer_run = 3'h0;
        end else if (next_st.pwr.sys_clk_off) begin
            next_st.pwr.timer_run = ~timer_clk_is_sys & timer_osc_en;
        end else begin
            next_st.pwr.timer_run = timer_osc_en;
        end
    end

    // Register the state; outputs are taken straight from it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st               <= '0;
            st.state         <= IWC_ST_RUN;
            st.mode          <= IWC_MODE_RUN;
            st.edge_sel      <= `IWC_EDGE_RST;
            st.stack_pointer <= `IWC_SP_RST;
            st.pwr.timer_run <= 3'h0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata    = st.prdata;
    assign pready    = st.pready;
    assign pslverr   = st.pslverr;
    assign pc_out    = st.pc;
    assign af_out    = st.af;
    assign irq_taken = st.irq_taken;
    assign mem       = st.mem;
    assign pwr       = st.pwr;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_entry_vector;
        @(posedge clk) disable iff (rst)
        take_irq |=> pc_out.load && pc_out.value == `IWC_VECTOR && !st.gie;
    endproperty
    a_entry_vector: assert property (p_entry_vector) else $error("no vector jump");

    property p_entry_push;
        @(posedge clk) disable iff (rst)
        take_irq |=> mem.we && mem.addr == $past(st.stack_pointer)
                     && st.stack_pointer == $past(st.stack_pointer) + `IWC_SP_STEP;
    endproperty
    a_entry_push: assert property (p_entry_push) else $error("bad push");

    property p_return;
        @(posedge clk) disable iff (rst)
        (st.state == IWC_ST_RUN && !take_irq && instr.return_from_interrupt)
        |=> mem.re && st.stack_pointer == $past(st.stack_pointer) - `IWC_SP_STEP
        ##1 1'b1 ##1 pc_out.load && st.gie;
    endproperty
    a_return: assert property (p_return) else $error("bad return");

    property p_flag_masked;
        @(posedge clk) disable iff (rst)
        (line_event & ~st.enable) != 7'h00
        |=> (st.flags & $past(line_event)) == $past(line_event);
    endproperty
    a_flag_masked: assert property (p_flag_masked) else $error("flag lost");

    property p_flag_hw_only;
        @(posedge clk) disable iff (rst)
        ((st.flags & ~$past(st.flags)) & ~$past(line_event)) == 7'h00;
    endproperty
    a_flag_hw_only: assert property (p_flag_hw_only) else $error("flag set by sw");

    property p_no_take_without_gie;
        @(posedge clk) disable iff (rst)
        !st.gie |=> !irq_taken;
    endproperty
    a_no_take_without_gie: assert property (p_no_take_without_gie) else $error("gie");

    property p_deep_pin_only;
        @(posedge clk) disable iff (rst)
        (st.state == IWC_ST_SLEEP && st.mode == IWC_MODE_DEEP && pin_toggle == 8'h00)
        |=> st.state == IWC_ST_SLEEP && pwr.osc_stop_all;
    endproperty
    a_deep_pin_only: assert property (p_deep_pin_only) else $error("deep woke");

    property p_sleep_entry;
        @(posedge clk) disable iff (rst)
        (st.state == IWC_ST_RUN && !take_irq && instr.enter_light_sleep
         && !instr.return_from_interrupt && !instr.pop_acc_flags && !instr.push_acc_flags)
        |=> pwr.sys_clk_off && pwr.cpu_hold && pwr.prog_mem_off && !pwr.osc_stop_all;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("light sleep");

    property p_wake_hold;
        @(posedge clk) disable iff (rst)
        wake_start |=> pwr.cpu_hold throughout (wake_busy [*8]);
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("core ran early");

    c_irq:   cover property (@(posedge clk) disable iff (rst) irq_taken);
    c_ret:   cover property (@(posedge clk) disable iff (rst) pc_out.load && st.gie);
    c_wake:  cover property (@(posedge clk) disable iff (rst) wake_done);
    c_clear: cover property (@(posedge clk) disable iff (rst) apb_wr && paddr == `IWC_OFS_FLAGS);
endmodule
`default_nettype wire

/* verif/iwc_mem_model.sv */
// Stack data memory model beside the controller.
`default_nettype none
module iwc_mem_model import iwc_pkg::*; (
    // Clock and stack port.
    input  wire logic     clk,
    input  wire iwc_mem_s mem,
    output logic [15:0]   rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ram [256];
    // Reads answer a cycle later; other cycles flip the bus so stale data is caught.
    always @(posedge clk) begin
        if (mem.we)
            ram[mem.addr] <= mem.wdata;
        rdata <= mem.re ? ram[mem.addr] : ~rdata;
    end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench of the interrupt and wake-up controller.
`default_nettype none
`include "iwc_defines.svh"
module tb import iwc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, irq_boundary = 0;
    logic        pready, pslverr, irq_taken, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] pc_in = 0, mem_rdata, pc;
    logic [7:0]  acc_in = 0, flags_in = 0, wake_pin = 0, sp;
    logic [4:0]  periph_req = 0, ev;
    logic [2:0]  lro = 0, tsys = 0, tosc = 0;
    logic [1:0]  ext_pin = 0;
    iwc_instr_s  instr = '0;
    iwc_pc_s     pc_out;
    iwc_af_s     af_out;
    iwc_mem_s    mem;
    iwc_pwr_s    pwr;
    int          miscompares = 0, total_checks = 0, n, ln;
    assign ev = {pready, ~pwr.cpu_hold, af_out.load, pc_out.load, irq_taken};
    always #20 clk = ~clk;
    // Low-rate oscillator at an eighth of the clock, so wake counts stay short.
    always @(posedge clk)
        lro <= lro + 3'h1;
    iwc_ctrl dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_pin, .periph_req, .wake_pin, .low_rate_osc(lro[2]), .instr,
        .irq_boundary, .pc_in, .acc_in, .flags_in, .pc_out, .af_out, .irq_taken, .mem,
        .mem_rdata, .timer_clk_is_sys(tsys), .timer_osc_en(tosc), .pwr);
    iwc_mem_model mem_model (.clk, .mem, .rdata(mem_rdata));
    function automatic logic wake_ok(input int c, input int p);
        return c >= (p - 1) * 8 && c <= (p + 2) * 8;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Waits on one event bit, at most lim edges.
    task automatic wt(input int k, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ev[k] !== 1'b1 && n < lim);
        chk("wait", 32'(n < lim), 1);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        wt(4, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input iwc_instr_s s);
        instr <= s;
        @(posedge clk);
        instr <= '0;
    endtask
    task automatic complete_run;
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence: flags, entry and return, stack, sleep and wake.
    initial begin
        void'($urandom(32'ha702));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        apb(0, `IWC_OFS_STACK, 0);
        chk("sp_rst", rd, 0);
        apb(0, 12'h0FC, 0);
        chk("unmapped", err, 1);
        ln = 2 + $urandom % 5;
        periph_req <= 5'(1 << (ln - 2));
        ext_pin <= 2'b11;
        repeat (4) @(posedge clk);
        apb(1, `IWC_OFS_FLAGS, 32'h7F);
        apb(0, `IWC_OFS_FLAGS, 0);
        chk("flag_dis", rd, (1 << ln) | 3);
        apb(1, `IWC_OFS_FLAGS, ~(32'h1 << ln));
        apb(0, `IWC_OFS_FLAGS, 0);
        chk("flag_clr", rd, 3);
        apb(1, `IWC_OFS_EDGE, 32'(`IWC_EDGE_FALL) << (2 * ln));
        periph_req <= 5'h00;
        repeat (4) @(posedge clk);
        apb(0, `IWC_OFS_FLAGS, 0);
        chk("flag_fall", rd, (1 << ln) | 3);
        apb(1, `IWC_OFS_FLAGS, ~(32'h1 << ln));
        periph_req <= 5'(1 << (ln - 2));
        repeat (4) @(posedge clk);
        apb(0, `IWC_OFS_FLAGS, 0);
        chk("fall_only", rd, 3);
        apb(1, `IWC_OFS_EDGE, 32'(`IWC_EDGE_RISE) << (2 * ln));
        periph_req <= 5'h00;
        repeat (4) @(posedge clk);
        apb(0, `IWC_OFS_FLAGS, 0);
        chk("rise_only", rd, 3);
        periph_req <= 5'(1 << (ln - 2));
        repeat (4) @(posedge clk);
        apb(0, `IWC_OFS_FLAGS, 0);
        chk("flag_rise", rd, (1 << ln) | 3);
        sp = 8'($urandom) & 8'hF0;
        pc = 16'($urandom);
        apb(1, `IWC_OFS_ENABLE, 1 << ln);
        apb(1, `IWC_OFS_STACK, sp);
        pc_in <= pc;
        irq_boundary <= 1'b1;
        pulse(7'h40);
        wt(0, 20);
        chk("vector", pc_out.value, `IWC_VECTOR);
        chk("push", {mem.we, mem.addr, mem.wdata}, {1'b1, sp, pc});
        irq_boundary <= 1'b0;
        apb(0, `IWC_OFS_STACK, 0);
        chk("sp_inc", rd, sp + 8'h02);
        apb(0, `IWC_OFS_STATUS, 0);
        chk("gie_off", rd[0], 0);
        pulse(7'h10);
        wt(1, 20);
        chk("ret_pc", pc_out.value, pc);
        apb(0, `IWC_OFS_STACK, 0);
        chk("sp_dec", rd, sp);
        apb(0, `IWC_OFS_STATUS, 0);
        chk("gie_on", rd[0], 1);
        acc_in <= 8'($urandom);
        flags_in <= 8'($urandom);
        pulse(7'h08);
        repeat (2) @(posedge clk);
        pulse(7'h04);
        wt(2, 20);
        chk("pop_af", {af_out.acc, af_out.flags}, {acc_in, flags_in});
        tosc <= 3'($urandom);
        tsys <= 3'($urandom);
        apb(1, `IWC_OFS_WAKE, 32'h20);
        apb(1, `IWC_OFS_DIE, 32'h01);
        pulse(7'h02);
        @(posedge clk);
        chk("light", {pwr.sys_clk_off, pwr.osc_stop_all, pwr.prog_mem_off}, 3'b101);
        chk("timers", pwr.timer_run, tosc & ~tsys);
        wake_pin <= 8'h01;
        wt(3, 1000);
        chk("wake_l", wake_ok(n, 45), 1);
        apb(1, `IWC_OFS_WAKE, 32'h00);
        pulse(7'h01);
        periph_req <= 5'h1E;
        wake_pin <= 8'hFF;
        repeat (100) @(posedge clk);
        chk("deep", {pwr.cpu_hold, pwr.osc_stop_all, pwr.timer_run}, 5'b11000);
        wake_pin <= 8'hFE;
        wt(3, 30000);
        chk("wake_d", wake_ok(n, 3000), 1);
        apb(0, `IWC_OFS_STATUS, 0);
        chk("run", rd[5:1], 0);
        complete_run;
    end
    // Watchdog well past the normal-speed wake, the longest wait of the run.
    initial begin
        #(40 * 40000);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire
